// [hdl/ttc_tx_ctrl.sv]
`timescale 1ns/1ps
module ttc_tx_ctrl (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_conversion,
  input wire logic i_esf_mode,
  input wire logic i_e1_mode,
  input wire logic i_send_remote_alarm,
  input wire logic i_send_ais,
  input wire ttc_pkg::ttc_word_t i_in_word,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output ttc_pkg::ttc_word_t o_out_word,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic o_tx_channel_clock_out,
  output logic o_bert_fbit_take,
  output logic [7:0] o_channel_monitor_data,
  output ttc_pkg::ttc_ctrl_t o_ctrl
);

  typedef struct packed {
    logic [7:0] store;
    logic [7:0] alarm;
    logic [7:0] hdlc;
    logic [7:0] interleaved_bus_operation;
    logic [7:0] mon;
    logic [7:0] bert;
    logic [7:0] supp;
    logic [7:0] sync;
    ttc_pkg::ttc_word_t buf0;
    ttc_pkg::ttc_word_t buf1;
    logic [1:0] count;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] monitor;
    logic [3:0] bitcnt;
    logic [7:0] shift_use;
    logic chclk;
    logic fbit_take;
    ttc_pkg::ttc_ctrl_t ctrl;
  } ttc_state_t;

  ttc_state_t st_r;
  ttc_state_t st_nxt;

  // Writable bits of each register; zero for an unmapped address
  function automatic logic [7:0] reg_mask(input logic [8:0] addr);
    case (addr)
      ttc_pkg::TTC_OFS_STORE: reg_mask = ttc_pkg::TTC_MASK_STORE;
      ttc_pkg::TTC_OFS_ALARM: reg_mask = ttc_pkg::TTC_MASK_ALARM;
      ttc_pkg::TTC_OFS_HDLC: reg_mask = ttc_pkg::TTC_MASK_HDLC;
      ttc_pkg::TTC_OFS_IBO: reg_mask = ttc_pkg::TTC_MASK_IBO;
      ttc_pkg::TTC_OFS_MON: reg_mask = ttc_pkg::TTC_MASK_MON;
      ttc_pkg::TTC_OFS_BERT: reg_mask = ttc_pkg::TTC_MASK_BERT;
      ttc_pkg::TTC_OFS_SUPP: reg_mask = ttc_pkg::TTC_MASK_SUPP;
      ttc_pkg::TTC_OFS_SYNC: reg_mask = ttc_pkg::TTC_MASK_SYNC;
      default: reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  // True when a write sets a bit that was clear
  function automatic logic rise(input logic old_bit, input logic new_bit);
    rise = ~old_bit & new_bit;
  endfunction : rise

  // Per-bit clock pattern of one outgoing word
  function automatic logic [7:0] bit_use(input logic fmt56, input logic fbit);
    if (fbit) begin
      bit_use = 8'h00;
    end else if (fmt56) begin
      bit_use = 8'hfe;
    end else begin
      bit_use = 8'hff;
    end
  endfunction : bit_use

  // Register image after reset; every control register starts cleared
  function automatic ttc_state_t reset_state();
    reset_state = '0;
    reset_state.store = ttc_pkg::TTC_REG_RESET;
    reset_state.alarm = ttc_pkg::TTC_REG_RESET;
    reset_state.hdlc = ttc_pkg::TTC_REG_RESET;
    reset_state.interleaved_bus_operation = ttc_pkg::TTC_REG_RESET;
    reset_state.mon = ttc_pkg::TTC_REG_RESET;
    reset_state.bert = ttc_pkg::TTC_REG_RESET;
    reset_state.supp = ttc_pkg::TTC_REG_RESET;
    reset_state.sync = ttc_pkg::TTC_REG_RESET;
  endfunction : reset_state

  // Read value of one register; unmapped addresses return zero
  function automatic logic [7:0] reg_read(input logic [8:0] addr, input ttc_state_t s);
    case (addr)
      ttc_pkg::TTC_OFS_STORE: reg_read = s.store;
      ttc_pkg::TTC_OFS_ALARM: reg_read = s.alarm;
      ttc_pkg::TTC_OFS_HDLC: reg_read = s.hdlc;
      ttc_pkg::TTC_OFS_IBO: reg_read = s.interleaved_bus_operation;
      ttc_pkg::TTC_OFS_MON: reg_read = s.mon;
      ttc_pkg::TTC_OFS_BERT: reg_read = s.bert;
      ttc_pkg::TTC_OFS_SUPP: reg_read = s.supp;
      ttc_pkg::TTC_OFS_SYNC: reg_read = s.sync;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Loop code length in bits for a two-bit code
  function automatic logic [4:0] loop_len(input logic [1:0] code);
    case (code)
      2'h0: loop_len = ttc_pkg::TTC_LC_0;
      2'h1: loop_len = ttc_pkg::TTC_LC_1;
      2'h2: loop_len = ttc_pkg::TTC_LC_2;
      default: loop_len = ttc_pkg::TTC_LC_3;
    endcase
  endfunction : loop_len

  // HDLC FIFO low watermark in bytes for a two-bit code
  function automatic logic [5:0] low_wm(input logic [1:0] code);
    case (code)
      2'h0: low_wm = ttc_pkg::TTC_WM_0;
      2'h1: low_wm = ttc_pkg::TTC_WM_1;
      2'h2: low_wm = ttc_pkg::TTC_WM_2;
      default: low_wm = ttc_pkg::TTC_WM_3;
    endcase
  endfunction : low_wm

  // Devices sharing the interleaved bus; zero marks the reserved code
  function automatic logic [3:0] bus_devices(input logic [1:0] code);
    case (code)
      2'h0: bus_devices = ttc_pkg::TTC_BUS_2;
      2'h1: bus_devices = ttc_pkg::TTC_BUS_4;
      2'h2: bus_devices = ttc_pkg::TTC_BUS_8;
      default: bus_devices = 4'h0;
    endcase
  endfunction : bus_devices

  // Alarm pattern for a request level and its mode bit
  function automatic ttc_pkg::ttc_pat_t alarm_pat(input logic send, input logic ci_mode);
    if (!send) begin
      alarm_pat = ttc_pkg::TTC_PAT_OFF;
    end else if (ci_mode) begin
      alarm_pat = ttc_pkg::TTC_PAT_CI;
    end else begin
      alarm_pat = ttc_pkg::TTC_PAT_NORMAL;
    end
  endfunction : alarm_pat

  // 56k stuffs the LSB, the channel bit 1, of every payload word
  function automatic ttc_pkg::ttc_word_t shape_word(input logic fmt56, input ttc_pkg::ttc_word_t w);
    shape_word = w;
    if (fmt56 && !w.fbit) begin
      shape_word.data[0] = 1'b1;
    end
  endfunction : shape_word

  logic wr_en;
  logic rd_en;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic push;
  logic pop;
  ttc_pkg::ttc_word_t shaped;

  always_comb begin
    st_nxt = st_r;
    wr_en = i_cs & i_wr;
    rd_en = i_cs & i_rd & ~i_wr;
    wmask = reg_mask(i_addr);
    wval = i_wdata & wmask;
    push = 1'b0;
    pop = 1'b0;
    shaped = i_in_word;

    // Register writes; reserved bits stay zero
    // Command pulses need a 0-to-1 write, so rewriting a one gives none
    st_nxt.ctrl.align_pulse = 1'b0;
    st_nxt.ctrl.reset_pulse = 1'b0;
    st_nxt.ctrl.resync_pulse = 1'b0;
    if (wr_en) begin
      case (i_addr)
        ttc_pkg::TTC_OFS_STORE: begin
          st_nxt.store = wval;
          st_nxt.ctrl.align_pulse = rise(st_r.store[ttc_pkg::TTC_B_ALGN], wval[ttc_pkg::TTC_B_ALGN]);
          st_nxt.ctrl.reset_pulse = rise(st_r.store[ttc_pkg::TTC_B_SRST], wval[ttc_pkg::TTC_B_SRST]);
        end
        ttc_pkg::TTC_OFS_ALARM: begin
          st_nxt.alarm = wval;
        end
        ttc_pkg::TTC_OFS_HDLC: begin
          st_nxt.hdlc = wval;
        end
        ttc_pkg::TTC_OFS_IBO: begin
          st_nxt.interleaved_bus_operation = wval;
        end
        ttc_pkg::TTC_OFS_MON: begin
          st_nxt.mon = wval;
        end
        ttc_pkg::TTC_OFS_BERT: begin
          st_nxt.bert = wval;
        end
        ttc_pkg::TTC_OFS_SUPP: begin
          st_nxt.supp = wval;
        end
        ttc_pkg::TTC_OFS_SYNC: begin
          st_nxt.sync = wval;
          st_nxt.ctrl.resync_pulse = rise(st_r.sync[ttc_pkg::TTC_B_RESYNC], wval[ttc_pkg::TTC_B_RESYNC]);
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped addresses return zero
    // A write wins over a read when both strobes are high
    st_nxt.rvalid = rd_en;
    if (rd_en) begin
      st_nxt.rdata = reg_read(i_addr, st_r);
    end

    // Elastic store controls
    st_nxt.ctrl.payload_56k = st_r.store[ttc_pkg::TTC_B_FMT];
    st_nxt.ctrl.gapped_clock = st_r.store[ttc_pkg::TTC_B_GCLK];
    st_nxt.ctrl.slip_force_en = i_conversion;
    if (!i_conversion) begin
      st_nxt.ctrl.slip_zone_bytes = 4'h0;
    end else if (st_r.store[ttc_pkg::TTC_B_SZS]) begin
      st_nxt.ctrl.slip_zone_bytes = ttc_pkg::TTC_SLIP_NARROW;
    end else begin
      st_nxt.ctrl.slip_zone_bytes = ttc_pkg::TTC_SLIP_WIDE;
    end
    st_nxt.ctrl.store_min_delay = st_r.store[ttc_pkg::TTC_B_MDM];
    st_nxt.ctrl.store_enable = st_r.store[ttc_pkg::TTC_B_SEN];

    // Alarm patterns; the remote alarm only exists in ESF framing
    st_nxt.ctrl.rai_pattern = alarm_pat(i_esf_mode & i_send_remote_alarm, st_r.alarm[ttc_pkg::TTC_B_RAIM]);
    st_nxt.ctrl.ais_pattern = alarm_pat(i_send_ais, st_r.alarm[ttc_pkg::TTC_B_AISM]);

    // Loop code length: codes 01 and 11 name the longest of their family
    st_nxt.ctrl.loop_code_length = st_r.alarm[1:0];
    st_nxt.ctrl.loop_len_bits = loop_len(st_r.alarm[1:0]);

    st_nxt.ctrl.fifo_low_watermark = low_wm(st_r.hdlc[1:0]);

    // Interleaved bus; the reserved size keeps the bus out of use
    st_nxt.ctrl.bus_devices = bus_devices(st_r.interleaved_bus_operation[ttc_pkg::TTC_B_IBS +: 2]);
    st_nxt.ctrl.bus_size_reserved = (st_nxt.ctrl.bus_devices == 4'h0);
    st_nxt.ctrl.frame_interleave = st_r.interleaved_bus_operation[ttc_pkg::TTC_B_INTERLEAVE_UNIT_SELECT];
    st_nxt.ctrl.ibo_active = st_r.interleaved_bus_operation[ttc_pkg::TTC_B_INTERLEAVE_ENABLE] & ~st_nxt.ctrl.bus_size_reserved;
    st_nxt.ctrl.bus_position = st_r.interleaved_bus_operation[2:0];

    // BERT port
    st_nxt.ctrl.bert_to_receive = st_r.bert[ttc_pkg::TTC_B_DIR];
    st_nxt.ctrl.bert_unframed = st_r.bert[ttc_pkg::TTC_B_FUS];
    st_nxt.ctrl.bert_port_active = st_r.bert[ttc_pkg::TTC_B_BEN];
    st_nxt.ctrl.bert_bit_use = st_r.bert[ttc_pkg::TTC_B_BEN] ? ~st_r.supp : 8'h00;

    // Synchronizer
    st_nxt.ctrl.sync_run = st_r.sync[ttc_pkg::TTC_B_SYNCHRONIZER_ENABLE];
    st_nxt.ctrl.auto_resync = st_r.sync[ttc_pkg::TTC_B_SYNCHRONIZER_ENABLE] & ~st_r.sync[ttc_pkg::TTC_B_AUTO];
    st_nxt.ctrl.crc_search = i_e1_mode & st_r.sync[ttc_pkg::TTC_B_CRC];

    // Shape the payload: 56k stuffs the LSB, the channel bit 1
    shaped = shape_word(st_r.store[ttc_pkg::TTC_B_FMT], i_in_word);

    // Two-entry buffer between producer and line
    // Ready looks only at the count, so a stalled line never costs a word
    push = i_in_valid & (st_r.count != 2'h2);
    pop = (st_r.count != 2'h0) & i_out_ready;
    case ({push, pop})
      2'b10: begin
        if (st_r.count == 2'h0) begin
          st_nxt.buf0 = shaped;
        end else begin
          st_nxt.buf1 = shaped;
        end
        st_nxt.count = st_r.count + 2'h1;
      end
      2'b01: begin
        st_nxt.buf0 = st_r.buf1;
        st_nxt.count = st_r.count - 2'h1;
      end
      2'b11: begin
        if (st_r.count == 2'h1) begin
          st_nxt.buf0 = shaped;
        end else begin
          st_nxt.buf0 = st_r.buf1;
          st_nxt.buf1 = shaped;
        end
      end
      default: begin
      end
    endcase

    // Channel monitor captures the selected channel as it leaves
    if (pop && !st_r.buf0.fbit && st_r.buf0.chan == st_r.mon[4:0]) begin
      st_nxt.monitor = st_r.buf0.data;
    end

    // Channel clock: one pulse per word, or one per payload bit when gapped
    // A new pop restarts the pattern at once
    st_nxt.fbit_take = 1'b0;
    if (pop) begin
      st_nxt.bitcnt = ttc_pkg::TTC_BITS_WORD - 4'h1;
      st_nxt.shift_use = bit_use(st_r.store[ttc_pkg::TTC_B_FMT], st_r.buf0.fbit);
      st_nxt.fbit_take = st_r.buf0.fbit & st_r.bert[ttc_pkg::TTC_B_BEN]
                         & st_r.bert[ttc_pkg::TTC_B_FUS] & ~st_r.bert[ttc_pkg::TTC_B_DIR];
      if (st_r.store[ttc_pkg::TTC_B_GCLK]) begin
        st_nxt.chclk = st_nxt.shift_use[7];
      end else begin
        st_nxt.chclk = 1'b1;
      end
    end else if (st_r.bitcnt != 4'h0) begin
      st_nxt.bitcnt = st_r.bitcnt - 4'h1;
      st_nxt.shift_use = {st_r.shift_use[6:0], 1'b0};
      st_nxt.chclk = st_r.store[ttc_pkg::TTC_B_GCLK] & st_r.shift_use[6];
    end else begin
      st_nxt.chclk = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= reset_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_rvalid = st_r.rvalid;
  assign o_in_ready = (st_r.count != 2'h2);
  assign o_out_word = st_r.buf0;
  assign o_out_valid = (st_r.count != 2'h0);
  assign o_tx_channel_clock_out = st_r.chclk;
  assign o_bert_fbit_take = st_r.fbit_take;
  assign o_channel_monitor_data = st_r.monitor;
  assign o_ctrl = st_r.ctrl;

endmodule : ttc_tx_ctrl

// [hdl/ttc_pkg.sv]
package ttc_pkg;
  localparam logic [8:0] TTC_OFS_STORE = 9'h185;
  localparam logic [8:0] TTC_OFS_ALARM = 9'h186;
  localparam logic [8:0] TTC_OFS_HDLC = 9'h187;
  localparam logic [8:0] TTC_OFS_IBO = 9'h188;
  localparam logic [8:0] TTC_OFS_MON = 9'h189;
  localparam logic [8:0] TTC_OFS_BERT = 9'h18a;
  localparam logic [8:0] TTC_OFS_SUPP = 9'h18b;
  localparam logic [8:0] TTC_OFS_SYNC = 9'h18e;
  localparam logic [7:0] TTC_MASK_STORE = 8'hdf;
  localparam logic [7:0] TTC_MASK_ALARM = 8'h0f;
  localparam logic [7:0] TTC_MASK_HDLC = 8'h03;
  localparam logic [7:0] TTC_MASK_IBO = 8'h7f;
  localparam logic [7:0] TTC_MASK_MON = 8'h1f;
  localparam logic [7:0] TTC_MASK_BERT = 8'h07;
  localparam logic [7:0] TTC_MASK_SUPP = 8'hff;
  localparam logic [7:0] TTC_MASK_SYNC = 8'h0f;
  localparam logic [7:0] TTC_REG_RESET = 8'h00;
  localparam int TTC_B_FMT = 7;
  localparam int TTC_B_GCLK = 6;
  localparam int TTC_B_SZS = 4;
  localparam int TTC_B_ALGN = 3;
  localparam int TTC_B_SRST = 2;
  localparam int TTC_B_MDM = 1;
  localparam int TTC_B_SEN = 0;
  localparam int TTC_B_RAIM = 3;
  localparam int TTC_B_AISM = 2;
  localparam int TTC_B_IBS = 5;
  localparam int TTC_B_INTERLEAVE_UNIT_SELECT = 4;
  localparam int TTC_B_INTERLEAVE_ENABLE = 3;
  localparam int TTC_B_DIR = 2;
  localparam int TTC_B_FUS = 1;
  localparam int TTC_B_BEN = 0;
  localparam int TTC_B_CRC = 3;
  localparam int TTC_B_SYNCHRONIZER_ENABLE = 2;
  localparam int TTC_B_AUTO = 1;
  localparam int TTC_B_RESYNC = 0;
  localparam logic [3:0] TTC_SLIP_WIDE = 4'h9;
  localparam logic [3:0] TTC_SLIP_NARROW = 4'h2;
  localparam logic [5:0] TTC_WM_0 = 6'h04;
  localparam logic [5:0] TTC_WM_1 = 6'h10;
  localparam logic [5:0] TTC_WM_2 = 6'h20;
  localparam logic [5:0] TTC_WM_3 = 6'h30;
  localparam logic [4:0] TTC_LC_0 = 5'h05;
  localparam logic [4:0] TTC_LC_1 = 5'h06;
  localparam logic [4:0] TTC_LC_2 = 5'h07;
  localparam logic [4:0] TTC_LC_3 = 5'h10;
  localparam logic [3:0] TTC_BUS_2 = 4'h2;
  localparam logic [3:0] TTC_BUS_4 = 4'h4;
  localparam logic [3:0] TTC_BUS_8 = 4'h8;
  localparam logic [3:0] TTC_BITS_WORD = 4'h8;
  typedef enum logic [1:0] {TTC_PAT_OFF, TTC_PAT_NORMAL, TTC_PAT_CI} ttc_pat_t;
  typedef struct packed {
    logic [7:0] data;
    logic [4:0] chan;
    logic fbit;
  } ttc_word_t;
  typedef struct packed {
    logic payload_56k;
    logic gapped_clock;
    logic slip_force_en;
    logic [3:0] slip_zone_bytes;
    logic align_pulse;
    logic reset_pulse;
    logic store_min_delay;
    logic store_enable;
    ttc_pat_t rai_pattern;
    ttc_pat_t ais_pattern;
    logic [1:0] loop_code_length;
    logic [4:0] loop_len_bits;
    logic [5:0] fifo_low_watermark;
    logic ibo_active;
    logic frame_interleave;
    logic bus_size_reserved;
    logic [3:0] bus_devices;
    logic [2:0] bus_position;
    logic bert_to_receive;
    logic bert_unframed;
    logic bert_port_active;
    logic [7:0] bert_bit_use;
    logic sync_run;
    logic auto_resync;
    logic resync_pulse;
    logic crc_search;
  } ttc_ctrl_t;
endpackage : ttc_pkg

// [verif/ttc_tx_ctrl_assertions.sv]
`timescale 1ns/1ps
module ttc_tx_ctrl_assertions (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic o_rvalid,
  input wire logic i_conversion,
  input wire logic i_esf_mode,
  input wire logic i_e1_mode,
  input wire logic o_out_valid,
  input wire logic i_out_ready,
  input wire ttc_pkg::ttc_word_t o_out_word,
  input wire logic o_tx_channel_clock_out,
  input wire ttc_pkg::ttc_ctrl_t o_ctrl
);
  logic wr_st;
  logic wr_sy;
  logic [1:0] al_q;
  logic [1:0] rs_q;
  logic [1:0] sy_q;
  logic rd_q;
  assign wr_st = i_cs && i_wr && i_addr == ttc_pkg::TTC_OFS_STORE;
  assign wr_sy = i_cs && i_wr && i_addr == ttc_pkg::TTC_OFS_SYNC;
  // Pulses may launch from the write edge or the decode edge after it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      al_q <= 2'h0;
      rs_q <= 2'h0;
      sy_q <= 2'h0;
      rd_q <= 1'b0;
    end else begin
      al_q <= {al_q[0], wr_st && i_wdata[3]};
      rs_q <= {rs_q[0], wr_st && i_wdata[2]};
      sy_q <= {sy_q[0], wr_sy && i_wdata[0]};
      rd_q <= i_cs && i_rd && !i_wr;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_read;
    i_cs && i_rd && !i_wr;
  endsequence
  sequence s_pop;
    o_out_valid && i_out_ready;
  endsequence
  chk_read_answer: assert property (s_read |=> o_rvalid) else $error("read not answered");
  chk_rvalid_cause: assert property (o_rvalid |-> rd_q) else $error("stray read valid");
  chk_align_cause: assert property (o_ctrl.align_pulse |-> |al_q)
    else $error("align pulse without write");
  chk_reset_cause: assert property (o_ctrl.reset_pulse |-> |rs_q)
    else $error("reset pulse without write");
  chk_resync_cause: assert property (o_ctrl.resync_pulse |-> |sy_q)
    else $error("resync pulse without write");
  chk_slip_gate: assert property (!i_conversion [*3] |-> !o_ctrl.slip_force_en)
    else $error("slip outside conversion");
  chk_rai_gate: assert property (!i_esf_mode [*3] |-> o_ctrl.rai_pattern == ttc_pkg::TTC_PAT_OFF)
    else $error("remote alarm outside esf");
  chk_crc_gate: assert property (!i_e1_mode [*3] |-> !o_ctrl.crc_search)
    else $error("crc search outside e1");
  chk_bus_reserved: assert property (o_ctrl.bus_size_reserved |-> !o_ctrl.ibo_active)
    else $error("reserved bus size active");
  chk_word_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_word))
    else $error("word lost in stall");
  chk_clock_pulse: assert property (s_pop ##1 !o_ctrl.gapped_clock |-> o_tx_channel_clock_out)
    else $error("no channel clock");
  chk_fmt_stuff: assert property (s_pop ##0 o_ctrl.payload_56k && !o_out_word.fbit |-> o_out_word.data[0])
    else $error("56k bit not stuffed");
endmodule : ttc_tx_ctrl_assertions

// [verif/ttc_sink_model.sv]
`timescale 1ns/1ps
module ttc_sink_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire ttc_pkg::ttc_word_t i_word,
  output logic o_ready,
  output logic [7:0] o_count,
  output ttc_pkg::ttc_word_t o_last
);
  assign o_ready = !i_stall;
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_count <= 8'h00;
      o_last <= '0;
    end else if (i_valid && o_ready) begin
      o_count <= o_count + 8'h01;
      o_last <= i_word;
    end
  end
endmodule : ttc_sink_model

// [verif/ttc_tx_ctrl_test.sv]
`timescale 1ns/1ps
module ttc_tx_ctrl_test;
  logic i_clk = 0, i_srst = 1, i_cs = 0, i_wr = 0, i_rd = 0, stall = 0, i_in_valid = 0;
  logic i_conversion = 0, i_esf_mode = 0, i_e1_mode = 0, i_send_remote_alarm = 0, i_send_ais = 0;
  logic [8:0] i_addr = 9'h000;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_channel_monitor_data, cnt;
  logic o_rvalid, o_in_ready, o_out_valid, i_out_ready, o_tx_channel_clock_out, o_bert_fbit_take;
  ttc_pkg::ttc_word_t i_in_word = '0, o_out_word, last_w;
  ttc_pkg::ttc_ctrl_t o_ctrl;
  int err_total = 0, tests_run = 0, np = 0, p, n;
  logic [8:0] ofs[8] = '{9'h185, 9'h186, 9'h187, 9'h188, 9'h189, 9'h18a, 9'h18b, 9'h18e};
  logic [7:0] msk[8] = '{8'hdf, 8'h0f, 8'h03, 8'h7f, 8'h1f, 8'h07, 8'hff, 8'h0f};
  logic [7:0] lc[4] = '{8'h05, 8'h06, 8'h07, 8'h10};
  logic [7:0] wm[4] = '{8'h04, 8'h10, 8'h20, 8'h30};
  logic [7:0] bs[4] = '{8'h02, 8'h04, 8'h08, 8'h00};
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) np <= np + (o_ctrl.align_pulse === 1'b1) + (o_ctrl.reset_pulse === 1'b1)
    + (o_ctrl.resync_pulse === 1'b1);
  ttc_tx_ctrl dut (.i_clk, .i_srst, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
    .i_conversion, .i_esf_mode, .i_e1_mode, .i_send_remote_alarm, .i_send_ais, .i_in_word,
    .i_in_valid, .o_in_ready, .o_out_word, .o_out_valid, .i_out_ready, .o_tx_channel_clock_out,
    .o_bert_fbit_take, .o_channel_monitor_data, .o_ctrl);
  ttc_sink_model sink (.i_clk, .i_srst, .i_stall(stall), .i_valid(o_out_valid), .i_word(o_out_word),
    .o_ready(i_out_ready), .o_count(cnt), .o_last(last_w));
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    i_cs = 1; i_wr = 1; i_addr = a; i_wdata = d;
    tick(1);
    i_cs = 0; i_wr = 0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    i_cs = 1; i_rd = 1; i_addr = a;
    tick(1);
    chk("rvalid", 16'h0001, 16'(o_rvalid));
    chk("rdata", 16'(e), 16'(o_rdata));
    i_cs = 0; i_rd = 0;
    tick(1);
  endtask : rd
  task automatic push(input logic [7:0] d, input logic [4:0] c, input logic f);
    i_in_word = '{d, c, f}; i_in_valid = 1;
    while (o_in_ready !== 1'b1) tick(1);
    tick(1);
    i_in_valid = 0;
    tick(1);
  endtask : push
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    tick(16);
    i_srst = 0;
    for (int i = 0; i < 8; i++) rd(ofs[i], 8'h00);
    rd(9'h18c, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ofs[i], 8'hff);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(9'h186, 8'(i));
      wr(9'h187, 8'(i));
      wr(9'h188, 8'(i * 32 + (i % 2) * 16 + 8 + i));
      tick(1);
      chk("loop", 16'(lc[i]), 16'(o_ctrl.loop_len_bits));
      chk("wmark", 16'(wm[i]), 16'(o_ctrl.fifo_low_watermark));
      chk("bus", 16'(bs[i]), 16'(o_ctrl.bus_devices));
      chk("ibo", 16'(i != 3), 16'(o_ctrl.ibo_active));
      chk("isel", 16'(i % 2), 16'(o_ctrl.frame_interleave));
      chk("pos", 16'(i), 16'(o_ctrl.bus_position));
      chk("lcode", 16'(i), 16'(o_ctrl.loop_code_length));
      chk("resv", 16'(i == 3), 16'(o_ctrl.bus_size_reserved));
      chk("zone0", 16'h0000, 16'({o_ctrl.slip_force_en, o_ctrl.slip_zone_bytes}));
    end
    $display("test decode done");
    wr(9'h189, 8'h05);
    push(8'h3c, 5'h05, 1'b0);
    tick(2);
    chk("monitor", 16'h003c, 16'(o_channel_monitor_data));
    wr(9'h185, 8'hc0);
    tick(1);
    chk("fmt", 16'h0003, 16'({o_ctrl.payload_56k, o_ctrl.gapped_clock}));
    push(8'h00, 5'h06, 1'b0);
    n = 0;
    repeat (8) begin
      n += int'(o_tx_channel_clock_out === 1'b1);
      tick(1);
    end
    chk("gapclk", 16'h0007, 16'(n));
    chk("stuff", 16'h0001, 16'(last_w.data));
    push(8'h00, 5'h06, 1'b1);
    tick(2);
    chk("fbit", 16'h0000, 16'(last_w.data));
    stall = 1;
    p = int'(cnt);
    push(8'h11, 5'h01, 1'b0);
    push(8'h22, 5'h02, 1'b0);
    chk("full", 16'h0000, 16'(o_in_ready));
    stall = 0;
    tick(4);
    chk("drain", 16'(p + 2), 16'(cnt));
    chk("empty", 16'h0000, 16'(o_out_valid));
    $display("test stream done");
    p = np;
    wr(9'h185, 8'h08);
    wr(9'h185, 8'h08);
    tick(2);
    chk("align", 16'(p + 1), 16'(np));
    wr(9'h185, 8'h00);
    wr(9'h185, 8'h08);
    wr(9'h185, 8'h04);
    wr(9'h185, 8'h00);
    wr(9'h18e, 8'h01);
    wr(9'h18e, 8'h01);
    wr(9'h18e, 8'h00);
    wr(9'h18e, 8'h01);
    tick(3);
    chk("pulses", 16'(p + 5), 16'(np));
    $display("test commands done");
    i_conversion = 1; i_esf_mode = 1; i_e1_mode = 1; i_send_ais = 1; i_send_remote_alarm = 1;
    wr(9'h185, 8'h13);
    wr(9'h186, 8'h0c);
    wr(9'h18a, 8'h07);
    wr(9'h18b, 8'h81);
    wr(9'h18e, 8'h0a);
    tick(1);
    chk("zone", 16'h0002, 16'(o_ctrl.slip_zone_bytes));
    chk("store", 16'h0003, 16'({o_ctrl.store_min_delay, o_ctrl.store_enable}));
    chk("pat", 16'({ttc_pkg::TTC_PAT_CI, ttc_pkg::TTC_PAT_CI}), 16'({o_ctrl.rai_pattern, o_ctrl.ais_pattern}));
    chk("bert", 16'h0007, 16'({o_ctrl.bert_to_receive, o_ctrl.bert_unframed, o_ctrl.bert_port_active}));
    chk("use", 16'h007e, 16'(o_ctrl.bert_bit_use));
    chk("sync", 16'h0001, 16'({o_ctrl.sync_run, o_ctrl.auto_resync, o_ctrl.crc_search}));
    chk("slipen", 16'h0001, 16'(o_ctrl.slip_force_en));
    push(8'h00, 5'h00, 1'b1);
    chk("ftake_rx", 16'h0000, 16'(o_bert_fbit_take));
    wr(9'h18a, 8'h03);
    push(8'h00, 5'h00, 1'b1);
    chk("ftake", 16'h0001, 16'(o_bert_fbit_take));
    tick(1);
    chk("ftake_end", 16'h0000, 16'(o_bert_fbit_take));
    wr(9'h185, 8'h00);
    wr(9'h186, 8'h00);
    wr(9'h18e, 8'h04);
    tick(1);
    chk("zone", 16'h0009, 16'(o_ctrl.slip_zone_bytes));
    chk("pat", 16'({ttc_pkg::TTC_PAT_NORMAL, ttc_pkg::TTC_PAT_NORMAL}), 16'({o_ctrl.rai_pattern, o_ctrl.ais_pattern}));
    chk("sync", 16'h0006, 16'({o_ctrl.sync_run, o_ctrl.auto_resync, o_ctrl.crc_search}));
    $display("test modes done");
    i_srst = 1;
    tick(2);
    i_srst = 0;
    for (int i = 0; i < 8; i++) rd(ofs[i], 8'h00);
    chk("rst_ctrl", 16'h0000, 16'({o_ctrl.bert_port_active, o_ctrl.sync_run, o_ctrl.ibo_active}));
    chk("rst_buf", 16'h0001, 16'({o_out_valid, o_in_ready}));
    $display("test reset done");
    wrap_up();
  end
endmodule : ttc_tx_ctrl_test
bind ttc_tx_ctrl ttc_tx_ctrl_assertions u_chk (.i_clk, .i_srst, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata,
  .o_rvalid, .i_conversion, .i_esf_mode, .i_e1_mode, .o_out_valid, .i_out_ready, .o_out_word,
  .o_tx_channel_clock_out, .o_ctrl);
